// ---- serial_output_config_regs.sv ----
// serial output configuration bank with its serial host link
`timescale 1ns/1ps
`include "serial_output_map.svh"

module serial_output_config_regs #(
    parameter logic [5:0] DATA_BITS = 6'd12
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic RESET_PIN_N_IN,
    input wire logic RESET_CLASS_APP_IN,
    input wire logic ALARM_IN,
    input wire logic LANE1_DATA_IN,
    input wire logic LINK_SCLK_IN,
    input wire logic LINK_CS_N_IN,
    input wire logic LINK_SDI_IN,
    output logic LINK_SDO_OUT,
    output logic GENERAL_OUTPUT_PIN_OUT,
    output logic SECOND_PIN_OUT,
    output logic SECOND_PIN_OE_OUT,
    output logic TWO_LANE_OUT,
    output logic OUT_CLOCK_POLARITY_OUT,
    output logic OUT_CLOCK_PHASE_OUT,
    output logic CONVERTER_CLOCKED_OUT,
    output logic TX_CLOCK_INTERNAL_OUT,
    output logic CONFIG_INVALID_OUT,
    output logic IN_CLOCK_POLARITY_OUT,
    output logic IN_CLOCK_PHASE_OUT,
    output logic [5:0] FRAME_BITS_OUT,
    output logic [2:0] DATA_VALUE_SELECT_OUT
);

    // ==========================================
    // link domain: frame shifter
    logic link_clr;
    logic [3:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    serial_output_pkg::link_frame_t frame_reg;
    logic req_tgl_reg;
    logic [7:0] tx_reg;
    logic [7:0] rd_byte_reg;

    // counter restarts whenever select is released
    assign link_clr = LINK_CS_N_IN | ~RST_N_IN;

    always_ff @(posedge LINK_SCLK_IN or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt_reg <= `LINK_BIT_CNT_RST;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge LINK_SCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            shift_reg <= 15'h0000;
        end else if (!LINK_CS_N_IN) begin
            shift_reg <= {shift_reg[13:0], LINK_SDI_IN};
        end
    end

    // frame held stable until the next one completes
    always_ff @(posedge LINK_SCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            frame_reg <= '0;
            req_tgl_reg <= 1'b0;
        end else if (!LINK_CS_N_IN && bit_cnt_reg == `LINK_LAST_BIT) begin
            frame_reg <= {shift_reg, LINK_SDI_IN};
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    // read byte of the previous frame goes out on bits 8..15
    always_ff @(posedge LINK_SCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_reg <= `RST_BYTE;
        end else if (!LINK_CS_N_IN) begin
            if (bit_cnt_reg == `LINK_RD_LOAD_BIT) begin
                tx_reg <= rd_byte_reg;
            end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    assign LINK_SDO_OUT = tx_reg[7];

    // ==========================================
    // crossing into the register clock
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_seen_reg;
    logic rst_pin_s1_reg;
    logic rst_pin_s2_reg;
    logic req_event;
    logic pin_reset;

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_seen_reg <= 1'b0;
        end else if (CE_IN) begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            req_seen_reg <= req_s2_reg;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            rst_pin_s1_reg <= 1'b1;
            rst_pin_s2_reg <= 1'b1;
        end else if (CE_IN) begin
            rst_pin_s1_reg <= RESET_PIN_N_IN;
            rst_pin_s2_reg <= rst_pin_s1_reg;
        end
    end

    assign req_event = req_s2_reg ^ req_seen_reg;
    assign pin_reset = ~rst_pin_s2_reg;

    // ==========================================
    // register storage
    serial_output_pkg::out_ctl_t out_ctl_reg;
    serial_output_pkg::word_fmt_t word_fmt_reg;
    logic [1:0] in_mode_reg;

    logic [31:0] out_ctl_word;
    logic [31:0] word_fmt_word;
    logic [31:0] in_proto_word;
    logic [31:0] sel_word;
    logic [31:0] wr_word;
    logic sel_hit;
    logic [6:0] req_base;
    logic [4:0] lane_shift;

    // read images: only implemented fields are placed, the rest stays zero
    always_comb begin
        out_ctl_word = 32'h0000_0000;
        out_ctl_word[`GEN_LEVEL_BIT] = out_ctl_reg.general_output_level;
        out_ctl_word[`ROLE_LSB +: 2] = out_ctl_reg.second_pin_role;
        out_ctl_word[`CLK_SEL_BIT] = out_ctl_reg.source_sync_clock_select;
        out_ctl_word[`MODE_LSB +: 2] = out_ctl_reg.output_protocol_select;
        word_fmt_word = 32'h0000_0000;
        word_fmt_word[`DEV_ADDR_INCL_BIT] = word_fmt_reg.dev_addr_incl;
        word_fmt_word[`VDD_INCL_LSB +: 2] = word_fmt_reg.vdd_alarm_incl;
        word_fmt_word[`IN_INCL_LSB +: 2] = word_fmt_reg.in_alarm_incl;
        word_fmt_word[`RANGE_INCL_BIT] = word_fmt_reg.range_incl;
        word_fmt_word[`PARITY_BIT] = word_fmt_reg.parity_enable;
        word_fmt_word[`DATA_VAL_LSB +: 3] = word_fmt_reg.data_value_select;
        in_proto_word = 32'h0000_0000;
        in_proto_word[`IN_MODE_LSB +: 2] = in_mode_reg;
    end

    // byte address to register word; two low bits pick the byte, lsb first
    always_comb begin
        req_base = {frame_reg.addr[6:2], 2'b00};
        lane_shift = {frame_reg.addr[1:0], 3'b000};
        sel_hit = 1'b1;
        unique case (req_base)
            `OUT_CTL_BASE: sel_word = out_ctl_word;
            `WORD_FMT_BASE: sel_word = word_fmt_word;
            `IN_PROTO_BASE: sel_word = in_proto_word;
            default: begin
                sel_word = 32'h0000_0000;
                sel_hit = 1'b0;
            end
        endcase
        wr_word = sel_word;
        wr_word[lane_shift +: 8] = frame_reg.data;
    end

    // fields of the output control register
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            out_ctl_reg <= '0;
        end else if (CE_IN) begin
            if (pin_reset) begin
                out_ctl_reg.general_output_level <= `RST_BIT;
                out_ctl_reg.second_pin_role <= serial_output_pkg::ROLE_HIGH_Z;
                if (!RESET_CLASS_APP_IN) begin
                    out_ctl_reg.source_sync_clock_select <= `RST_BIT;
                    out_ctl_reg.output_protocol_select <= serial_output_pkg::PROTO_FOLLOW_A;
                end
            end else if (req_event && frame_reg.wr && req_base == `OUT_CTL_BASE) begin
                out_ctl_reg.general_output_level <= wr_word[`GEN_LEVEL_BIT];
                out_ctl_reg.second_pin_role <= serial_output_pkg::second_pin_role_t'(wr_word[`ROLE_LSB +: 2]);
                out_ctl_reg.source_sync_clock_select <= wr_word[`CLK_SEL_BIT];
                out_ctl_reg.output_protocol_select <= serial_output_pkg::output_protocol_t'(wr_word[`MODE_LSB +: 2]);
            end
        end
    end

    // fields of the word-format register; parity enable survives app reset
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            word_fmt_reg <= '0;
        end else if (CE_IN) begin
            if (pin_reset) begin
                word_fmt_reg.dev_addr_incl <= `RST_BIT;
                word_fmt_reg.vdd_alarm_incl <= `RST_2BIT;
                word_fmt_reg.in_alarm_incl <= `RST_2BIT;
                word_fmt_reg.range_incl <= `RST_BIT;
                word_fmt_reg.data_value_select <= `RST_3BIT;
                if (!RESET_CLASS_APP_IN) begin
                    word_fmt_reg.parity_enable <= `RST_BIT;
                end
            end else if (req_event && frame_reg.wr && req_base == `WORD_FMT_BASE) begin
                word_fmt_reg.dev_addr_incl <= wr_word[`DEV_ADDR_INCL_BIT];
                word_fmt_reg.vdd_alarm_incl <= wr_word[`VDD_INCL_LSB +: 2];
                word_fmt_reg.in_alarm_incl <= wr_word[`IN_INCL_LSB +: 2];
                word_fmt_reg.range_incl <= wr_word[`RANGE_INCL_BIT];
                word_fmt_reg.parity_enable <= wr_word[`PARITY_BIT];
                word_fmt_reg.data_value_select <= wr_word[`DATA_VAL_LSB +: 3];
            end
        end
    end

    // input protocol mode, power-on class only
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            in_mode_reg <= `RST_2BIT;
        end else if (CE_IN) begin
            if (pin_reset) begin
                if (!RESET_CLASS_APP_IN) begin
                    in_mode_reg <= `RST_2BIT;
                end
            end else if (req_event && frame_reg.wr && req_base == `IN_PROTO_BASE) begin
                in_mode_reg <= wr_word[`IN_MODE_LSB +: 2];
            end
        end
    end

    // read byte for the next frame; unmapped reads give zero
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            rd_byte_reg <= `RST_BYTE;
        end else if (CE_IN && req_event && !frame_reg.wr) begin
            rd_byte_reg <= sel_hit ? sel_word[lane_shift +: 8] : `RST_BYTE;
        end
    end

    // ==========================================
    // pins and decoded output settings
    logic mode_follows_input;
    logic mode_conv_clocked;

    assign mode_follows_input = ~out_ctl_reg.output_protocol_select[1];
    assign mode_conv_clocked = out_ctl_reg.output_protocol_select == serial_output_pkg::PROTO_CONV_CLOCKED;

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            GENERAL_OUTPUT_PIN_OUT <= 1'b0;
        end else if (CE_IN) begin
            GENERAL_OUTPUT_PIN_OUT <= out_ctl_reg.general_output_level;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            SECOND_PIN_OUT <= 1'b0;
            SECOND_PIN_OE_OUT <= 1'b0;
            TWO_LANE_OUT <= 1'b0;
        end else if (CE_IN) begin
            unique case (out_ctl_reg.second_pin_role)
                serial_output_pkg::ROLE_HIGH_Z: begin
                    SECOND_PIN_OUT <= 1'b0;
                    SECOND_PIN_OE_OUT <= 1'b0;
                    TWO_LANE_OUT <= 1'b0;
                end
                serial_output_pkg::ROLE_ALARM: begin
                    SECOND_PIN_OUT <= ALARM_IN;
                    SECOND_PIN_OE_OUT <= 1'b1;
                    TWO_LANE_OUT <= 1'b0;
                end
                serial_output_pkg::ROLE_GENERAL: begin
                    SECOND_PIN_OUT <= out_ctl_reg.general_output_level;
                    SECOND_PIN_OE_OUT <= 1'b1;
                    TWO_LANE_OUT <= 1'b0;
                end
                serial_output_pkg::ROLE_SECOND_LANE: begin
                    SECOND_PIN_OUT <= LANE1_DATA_IN;
                    SECOND_PIN_OE_OUT <= 1'b1;
                    TWO_LANE_OUT <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            OUT_CLOCK_POLARITY_OUT <= 1'b0;
            OUT_CLOCK_PHASE_OUT <= 1'b0;
            IN_CLOCK_POLARITY_OUT <= 1'b0;
            IN_CLOCK_PHASE_OUT <= 1'b0;
        end else if (CE_IN) begin
            IN_CLOCK_POLARITY_OUT <= in_mode_reg[1];
            IN_CLOCK_PHASE_OUT <= in_mode_reg[0];
            OUT_CLOCK_POLARITY_OUT <= mode_follows_input & in_mode_reg[1];
            OUT_CLOCK_PHASE_OUT <= mode_follows_input & in_mode_reg[0];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            CONVERTER_CLOCKED_OUT <= 1'b0;
            TX_CLOCK_INTERNAL_OUT <= 1'b0;
            CONFIG_INVALID_OUT <= 1'b0;
        end else if (CE_IN) begin
            CONVERTER_CLOCKED_OUT <= mode_conv_clocked;
            TX_CLOCK_INTERNAL_OUT <= mode_conv_clocked & out_ctl_reg.source_sync_clock_select;
            CONFIG_INVALID_OUT <=
                out_ctl_reg.output_protocol_select == serial_output_pkg::PROTO_INVALID;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            FRAME_BITS_OUT <= DATA_BITS;
            DATA_VALUE_SELECT_OUT <= `RST_3BIT;
        end else if (CE_IN) begin
            FRAME_BITS_OUT <= word_fmt_reg.parity_enable ? 6'(DATA_BITS + `PARITY_EXTRA_BITS) : DATA_BITS;
            DATA_VALUE_SELECT_OUT <= word_fmt_reg.data_value_select;
        end
    end

endmodule // serial_output_config_regs

// ---- serial_output_map.svh ----
// byte addresses, field positions and reset values of the serial output configuration bank
`ifndef SERIAL_OUTPUT_MAP_SVH
`define SERIAL_OUTPUT_MAP_SVH

// ==========================================
// byte addresses (register base, lsb byte)
`define IN_PROTO_BASE 7'h08
`define OUT_CTL_BASE 7'h0C
`define WORD_FMT_BASE 7'h10

// ==========================================
// serial_output_control fields
`define GEN_LEVEL_BIT 12
`define ROLE_LSB 8
`define CLK_SEL_BIT 6
`define MODE_LSB 0

// ==========================================
// input_protocol_control fields
`define IN_MODE_LSB 0

// ==========================================
// output_word_format_control fields
`define DEV_ADDR_INCL_BIT 14
`define VDD_INCL_LSB 12
`define IN_INCL_LSB 10
`define RANGE_INCL_BIT 8
`define PARITY_BIT 3
`define DATA_VAL_LSB 0
`define PARITY_EXTRA_BITS 6'h02

// ==========================================
// reset values
`define RST_BIT 1'b0
`define RST_2BIT 2'h0
`define RST_3BIT 3'h0
`define RST_BYTE 8'h00

// ==========================================
// link frame layout
`define LINK_LAST_BIT 4'hF
`define LINK_RD_LOAD_BIT 4'h7
`define LINK_BIT_CNT_RST 4'h0

`endif

// ---- serial_output_pkg.sv ----
// types shared by the serial output configuration bank
package serial_output_pkg;

    // one host frame: write flag, byte address, data byte
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } link_frame_t;

    typedef enum logic [1:0] {
        PROTO_FOLLOW_A = 2'b00,
        PROTO_FOLLOW_B = 2'b01,
        PROTO_INVALID = 2'b10,
        PROTO_CONV_CLOCKED = 2'b11
    } output_protocol_t;

    typedef enum logic [1:0] {
        ROLE_HIGH_Z = 2'b00,
        ROLE_ALARM = 2'b01,
        ROLE_GENERAL = 2'b10,
        ROLE_SECOND_LANE = 2'b11
    } second_pin_role_t;

    typedef struct packed {
        logic general_output_level;
        second_pin_role_t second_pin_role;
        logic source_sync_clock_select;
        output_protocol_t output_protocol_select;
    } out_ctl_t;

    typedef struct packed {
        logic dev_addr_incl;
        logic [1:0] vdd_alarm_incl;
        logic [1:0] in_alarm_incl;
        logic range_incl;
        logic parity_enable;
        logic [2:0] data_value_select;
    } word_fmt_t;

endpackage

// ---- serial_output_config_regs_properties.sv ----
// concurrent checks on the serial output configuration bank ports
`timescale 1ns/1ps

module serial_output_config_regs_properties #(
    parameter logic [5:0] DATA_BITS = 6'h0C
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic RESET_PIN_N_IN,
    input wire logic RESET_CLASS_APP_IN,
    input wire logic LANE1_DATA_IN,
    input wire logic GENERAL_OUTPUT_PIN_OUT,
    input wire logic SECOND_PIN_OUT,
    input wire logic SECOND_PIN_OE_OUT,
    input wire logic TWO_LANE_OUT,
    input wire logic OUT_CLOCK_POLARITY_OUT,
    input wire logic OUT_CLOCK_PHASE_OUT,
    input wire logic CONVERTER_CLOCKED_OUT,
    input wire logic TX_CLOCK_INTERNAL_OUT,
    input wire logic CONFIG_INVALID_OUT,
    input wire logic IN_CLOCK_POLARITY_OUT,
    input wire logic IN_CLOCK_PHASE_OUT,
    input wire logic [5:0] FRAME_BITS_OUT,
    input wire logic [2:0] DATA_VALUE_SELECT_OUT
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // ==========================================
    // properties
    property p_lane_route;
        TWO_LANE_OUT && $past(CE_IN) |-> SECOND_PIN_OE_OUT && SECOND_PIN_OUT == $past(LANE1_DATA_IN);
    endproperty
    a_lane_route: assert property (p_lane_route)
        else $error("second lane does not carry lane data");

    property p_conv_pol;
        CONVERTER_CLOCKED_OUT |-> !OUT_CLOCK_POLARITY_OUT && !OUT_CLOCK_PHASE_OUT;
    endproperty
    a_conv_pol: assert property (p_conv_pol)
        else $error("converter clocked output still follows input clock mode");

    property p_follow_in;
        !CONVERTER_CLOCKED_OUT && !CONFIG_INVALID_OUT |->
            OUT_CLOCK_POLARITY_OUT == IN_CLOCK_POLARITY_OUT && OUT_CLOCK_PHASE_OUT == IN_CLOCK_PHASE_OUT;
    endproperty
    a_follow_in: assert property (p_follow_in)
        else $error("output clock mode differs from input clock mode");

    property p_tx_gate;
        TX_CLOCK_INTERNAL_OUT |-> CONVERTER_CLOCKED_OUT;
    endproperty
    a_tx_gate: assert property (p_tx_gate)
        else $error("internal transmit clock outside converter clocked mode");

    property p_frame_len;
        FRAME_BITS_OUT == DATA_BITS || FRAME_BITS_OUT == DATA_BITS + 6'h02;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length is neither base nor base plus two");

    property p_por_clear;
        disable iff (1'b0)
        !RST_N_IN |=> !GENERAL_OUTPUT_PIN_OUT && !SECOND_PIN_OE_OUT && !CONVERTER_CLOCKED_OUT
            && !TX_CLOCK_INTERNAL_OUT && !IN_CLOCK_POLARITY_OUT && FRAME_BITS_OUT == DATA_BITS;
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("outputs not cleared by power-on reset");

    property p_app_clear;
        (!RESET_PIN_N_IN && CE_IN) [*4] |=> !GENERAL_OUTPUT_PIN_OUT && !SECOND_PIN_OE_OUT
            && DATA_VALUE_SELECT_OUT == 3'h0;
    endproperty
    a_app_clear: assert property (p_app_clear)
        else $error("user settings survive a pin reset");

    property p_por_class;
        (!RESET_PIN_N_IN && !RESET_CLASS_APP_IN && CE_IN) [*4] |=> !CONVERTER_CLOCKED_OUT
            && !IN_CLOCK_POLARITY_OUT && !IN_CLOCK_PHASE_OUT && FRAME_BITS_OUT == DATA_BITS;
    endproperty
    a_por_class: assert property (p_por_class)
        else $error("power-on class pin reset left settings");

    c_two_lane: cover property (TWO_LANE_OUT);
    c_tx_int: cover property (TX_CLOCK_INTERNAL_OUT);
    c_parity: cover property (FRAME_BITS_OUT != DATA_BITS);
endmodule // serial_output_config_regs_properties

// ---- host_link_model.sv ----
// host controller model driving the serial configuration link
`timescale 1ns/1ps

module host_link_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b1;
    end

    // one frame; clock idles low between frames; returns bits 8..15 of sdo
    task automatic xfer(input serial_output_pkg::link_frame_t f, output logic [7:0] rd);
        cs_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_out = f[i];
            #3 sclk_out = 1'b1;
            #3 sclk_out = 1'b0;
            if (i <= 8 && i >= 1) rd[i - 1] = sdo_in;
        end
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule // host_link_model

// ---- tb_serial_output_config_regs.sv ----
// self-checking bench for the serial output configuration bank
`timescale 1ns/1ps

module tb_serial_output_config_regs;
    localparam logic [5:0] DBITS = 6'h0C;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic pin_rst_n = 1'b1;
    logic class_app = 1'b0;
    logic alarm = 1'b0;
    logic lane1 = 1'b0;
    logic sclk, cs_n, sdi, sdo, gen, sp, sp_oe, two, opol, opha, conv, txi, inval, ipol, ipha;
    logic [5:0] fbits;
    logic [2:0] dvs;
    int mem [0:127];
    int n_mismatch = 0;
    int total_checks = 0;

    always #20 clk = ~clk;

    serial_output_config_regs #(.DATA_BITS(DBITS)) serial_output_config_regs_i (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .RESET_PIN_N_IN(pin_rst_n),
        .RESET_CLASS_APP_IN(class_app), .ALARM_IN(alarm), .LANE1_DATA_IN(lane1),
        .LINK_SCLK_IN(sclk), .LINK_CS_N_IN(cs_n), .LINK_SDI_IN(sdi), .LINK_SDO_OUT(sdo),
        .GENERAL_OUTPUT_PIN_OUT(gen), .SECOND_PIN_OUT(sp), .SECOND_PIN_OE_OUT(sp_oe), .TWO_LANE_OUT(two),
        .OUT_CLOCK_POLARITY_OUT(opol), .OUT_CLOCK_PHASE_OUT(opha), .CONVERTER_CLOCKED_OUT(conv),
        .TX_CLOCK_INTERNAL_OUT(txi), .CONFIG_INVALID_OUT(inval), .IN_CLOCK_POLARITY_OUT(ipol),
        .IN_CLOCK_PHASE_OUT(ipha), .FRAME_BITS_OUT(fbits), .DATA_VALUE_SELECT_OUT(dvs));

    host_link_model host_link_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));

    // ==========================================
    // reference model and helpers
    function automatic int msk(input int a);
        case (a)
            8: return 8'h03;
            12: return 8'h43;
            13: return 8'h13;
            16: return 8'h0F;
            17: return 8'h7D;
            default: return 0;
        endcase
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input int a, input int d);
        logic [7:0] rd;
        host_link_model_i.xfer({1'b1, 7'(a), 8'(d)}, rd);
        mem[a] = d & msk(a);
        repeat (8) @(negedge clk);
    endtask

    task automatic rdchk(input int a);
        logic [7:0] d;
        host_link_model_i.xfer({1'b0, 7'(a), 8'h00}, d);
        repeat (8) @(negedge clk);
        host_link_model_i.xfer({1'b0, 7'h7F, 8'h00}, d);
        repeat (8) @(negedge clk);
        chk(d, 8'(mem[a]));
    endtask

    task automatic rdall();
        for (int a = 8; a < 20; a++) rdchk(a);
        rdchk(32);
    endtask

    task automatic outs();
        int m, r, im;
        m = mem[12] & 3;
        r = mem[13] & 3;
        im = mem[8] & 3;
        @(negedge clk);
        chk(gen, 8'(mem[13] >> 4 & 1));
        chk(two, 8'(r == 3));
        chk(sp_oe, 8'(r != 0));
        if (r != 0) chk(sp, 8'(r == 1 ? alarm : r == 2 ? mem[13] >> 4 & 1 : lane1));
        chk(conv, 8'(m == 3));
        chk(inval, 8'(m == 2));
        chk(txi, 8'(m == 3 && (mem[12] >> 6 & 1)));
        chk(ipol, 8'(im >> 1));
        chk(ipha, 8'(im & 1));
        chk(opol, 8'(m < 2 ? im >> 1 : 0));
        chk(opha, 8'(m < 2 ? im & 1 : 0));
        chk(8'(fbits), 8'(DBITS + (mem[16] >> 3 & 1) * 2));
        chk(8'(dvs), 8'(mem[16] & 7));
    endtask

    task automatic pin_reset(input logic app);
        class_app = app;
        pin_rst_n = 1'b0;
        repeat (6) @(negedge clk);
        pin_rst_n = 1'b1;
        repeat (4) @(negedge clk);
        mem[13] = 0;
        mem[17] = 0;
        mem[16] &= 8;
        if (!app) begin
            mem[12] = 0;
            mem[8] = 0;
            mem[16] = 0;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial begin
        int a, d;
        void'($urandom(32'hC52B));
        foreach (mem[i]) mem[i] = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        outs();
        rdall();
        $display("test reset values done");
        repeat (24) begin
            a = 8 + int'($urandom_range(11));
            d = int'($urandom_range(255));
            if (a == 12 && (d & 3) == 2) d ^= 1;
            alarm = 1'($urandom);
            lane1 = 1'($urandom);
            wr(a, d);
            outs();
        end
        wr(32, 8'hFF);
        rdall();
        $display("test random writes done");
        for (int r = 0; r < 4; r++) begin
            for (int m = 0; m < 4; m++) begin
                if (m == 2) continue;
                lane1 = ~lane1;
                wr(13, r | 16 * (m & 1));
                wr(12, m | 64 * (r & 1));
                outs();
            end
        end
        $display("test role and mode sweep done");
        // write lands while frozen, applies once enable returns
        a = mem[13];
        ce = 1'b0;
        wr(13, 8'h02);
        d = mem[13];
        mem[13] = a;
        outs();
        ce = 1'b1;
        mem[13] = d;
        repeat (8) @(negedge clk);
        outs();
        $display("test clock enable hold done");
        wr(17, 8'hFF);
        wr(16, 8'hFF);
        wr(8, 8'h02);
        wr(13, 8'hFF);
        outs();
        pin_reset(1'b1);
        outs();
        rdall();
        $display("test application reset done");
        wr(13, 8'h1F);
        pin_reset(1'b0);
        outs();
        rdall();
        $display("test power-on class reset done");
        results();
    end

    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
endmodule // tb_serial_output_config_regs

bind serial_output_config_regs serial_output_config_regs_properties #(.DATA_BITS(DATA_BITS)) props_i (
    .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .RESET_PIN_N_IN(RESET_PIN_N_IN),
    .RESET_CLASS_APP_IN(RESET_CLASS_APP_IN), .LANE1_DATA_IN(LANE1_DATA_IN),
    .GENERAL_OUTPUT_PIN_OUT(GENERAL_OUTPUT_PIN_OUT), .SECOND_PIN_OUT(SECOND_PIN_OUT),
    .SECOND_PIN_OE_OUT(SECOND_PIN_OE_OUT), .TWO_LANE_OUT(TWO_LANE_OUT),
    .OUT_CLOCK_POLARITY_OUT(OUT_CLOCK_POLARITY_OUT), .OUT_CLOCK_PHASE_OUT(OUT_CLOCK_PHASE_OUT),
    .CONVERTER_CLOCKED_OUT(CONVERTER_CLOCKED_OUT), .TX_CLOCK_INTERNAL_OUT(TX_CLOCK_INTERNAL_OUT),
    .CONFIG_INVALID_OUT(CONFIG_INVALID_OUT), .IN_CLOCK_POLARITY_OUT(IN_CLOCK_POLARITY_OUT),
    .IN_CLOCK_PHASE_OUT(IN_CLOCK_PHASE_OUT), .FRAME_BITS_OUT(FRAME_BITS_OUT),
    .DATA_VALUE_SELECT_OUT(DATA_VALUE_SELECT_OUT));
